//--- rtl/tmseq_pkg.sv
// constants for the threshold monitor sequencer
// assumes a 25 MHz core clock
package tmseq_pkg;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int          CLOCK_PERIOD_PS   = 40000;
   localparam int          COMPARE_TIME_PS   = 1600000;
   localparam int          COMPARE_CYCLES    = COMPARE_TIME_PS / CLOCK_PERIOD_PS;
   localparam logic [5:0]  COMPARE_LAST      = 6'(COMPARE_CYCLES - 1);
   localparam int          WAKE_CYCLES       = 120;
   localparam logic [6:0]  WAKE_LAST         = 7'(WAKE_CYCLES - 1);
   // -------------------------------------------------------------
   // table layout
   // -------------------------------------------------------------
   localparam int          ENTRIES           = 16;
   localparam int          CHANNELS          = 16;
   localparam int          CHANNEL_MSB       = 3;
   localparam int          PAIR_BIT          = 4;
   localparam int          LIST_BITS         = 5;
   localparam int          THRESH_BITS       = 8;
   localparam int          THRESH_LSB        = 2;
   localparam logic [3:0]  INDEX_RESET       = 4'h0;
   localparam logic [7:0]  THRESH_RESET      = 8'h00;
   localparam logic [4:0]  LIST_RESET        = 5'h00;
   localparam logic [15:0] PIN_SELECT_RESET  = 16'h0000;
   localparam logic [15:0] FLAGS_RESET       = 16'h0000;

   typedef enum logic [1:0] {
      TMSEQ_IDLE = 2'b00,
      TMSEQ_WAKE = 2'b01,
      TMSEQ_LOW  = 2'b10,
      TMSEQ_HIGH = 2'b11
   } tmseq_state_type;
endpackage

//--- rtl/tmseq_table.sv
// one threshold or list table: 16 entries written at an index
// assumes write strobes are one-cycle pulses on i_clock
`timescale 1ns/1ps
`default_nettype none
module tmseq_table
   import tmseq_pkg::*;
#(
   parameter int          WIDTH = 8,
   parameter logic [15:0] RESET_WORD = 16'h0000
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst_b,
   input  wire logic             i_write,
   input  wire logic [3:0]       i_index,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic [3:0]       i_scan_index,
   output logic      [WIDTH-1:0] o_host_word,
   output logic      [WIDTH-1:0] o_scan_word
);
   logic [WIDTH-1:0] store      [ENTRIES];
   logic [WIDTH-1:0] next_store [ENTRIES];

   always_comb begin
      for (int i = 0; i < ENTRIES; i++) begin
         next_store[i] = store[i];
      end
      if (i_write) begin
         next_store[i_index] = i_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < ENTRIES; i++) begin
            store[i] <= RESET_WORD[WIDTH-1:0];
         end
      end else begin
         for (int i = 0; i < ENTRIES; i++) begin
            store[i] <= next_store[i];
         end
      end
   end

   assign o_host_word = store[i_index];
   assign o_scan_word = store[i_scan_index];
endmodule
`default_nettype wire

//--- rtl/tmseq_top.sv
// threshold monitor sequencer: tables, scan engine and trip flags
// assumes a synchronous comparator result and a host that strobes the data port
// Operation
// [R1] channel mux picks one of sixteen inputs
// [R2] enabled scan loops entries round robin
// [R3] sixteen low and sixteen high thresholds
// [R4] selects route data port to table
// [R5] index advances after each port access
// [R6] sixteen list entries written via port
// [R7] list entry: channel plus pair bit
// [R8] scan between first and last entry
// [R9] repeated channels keep separate entries
// [R10] threshold drives dac, comparator judges input
// [R11] each compare 1.6 us, entry 3.2
// [R12] pins digital until analog select set
// [R13] wake 120 clocks before scanning
// [R14] first above last wraps past 15
// [R15] below low or above high trips
// [R16] one flag bit per list position
// [R17] flags stay set until cleared
`timescale 1ns/1ps
`default_nettype none
module tmseq_top
   import tmseq_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_monitor_enable,
   input  wire logic        i_list_access_select,
   input  wire logic        i_high_threshold_select,
   input  wire logic        i_index_load,
   input  wire logic [3:0]  i_index_value,
   input  wire logic        i_port_write,
   input  wire logic        i_port_read,
   input  wire logic [15:0] i_port_wdata,
   input  wire logic [3:0]  i_scan_first_entry,
   input  wire logic [3:0]  i_scan_last_entry,
   input  wire logic [15:0] i_analog_pin_select,
   input  wire logic        i_compare_above,
   input  wire logic [15:0] i_below_clear,
   input  wire logic [15:0] i_above_clear,
   output logic      [3:0]  o_table_index,
   output logic      [15:0] o_port_rdata,
   output logic      [15:0] o_pin_analog,
   output logic      [3:0]  o_mux_channel,
   output logic             o_mux_pair_mode,
   output logic      [7:0]  o_dac_code,
   output logic             o_scanning,
   output logic      [3:0]  o_scan_entry,
   output logic      [15:0] o_below_trip_flags,
   output logic      [15:0] o_above_trip_flags
);
   // -------------------------------------------------------------
   // data port and tables
   // -------------------------------------------------------------
   logic [3:0]  next_table_index;
   logic [15:0] next_port_rdata;
   logic [15:0] next_pin_analog;
   logic [7:0]  low_host, high_host, low_scan, high_scan;
   logic [4:0]  list_host, list_scan;
   logic        low_write, high_write, list_write;
   logic [3:0]  scan_entry;

   assign list_write = i_port_write & i_list_access_select;                     // [R6]
   assign low_write  = i_port_write & ~i_list_access_select & ~i_high_threshold_select; // [R4]
   assign high_write = i_port_write & ~i_list_access_select & i_high_threshold_select;  // [R4]

   tmseq_table #(.WIDTH(THRESH_BITS), .RESET_WORD({8'h00, THRESH_RESET})) u_low (    // [R3]
      .i_clock      (i_clock),
      .i_rst_b      (i_rst_b),
      .i_write      (low_write),
      .i_index      (o_table_index),
      .i_data       (i_port_wdata[THRESH_LSB +: THRESH_BITS]),
      .i_scan_index (scan_entry),
      .o_host_word  (low_host),
      .o_scan_word  (low_scan)
   );
   tmseq_table #(.WIDTH(THRESH_BITS), .RESET_WORD({8'h00, THRESH_RESET})) u_high (   // [R3]
      .i_clock      (i_clock),
      .i_rst_b      (i_rst_b),
      .i_write      (high_write),
      .i_index      (o_table_index),
      .i_data       (i_port_wdata[THRESH_LSB +: THRESH_BITS]),
      .i_scan_index (scan_entry),
      .o_host_word  (high_host),
      .o_scan_word  (high_scan)
   );
   tmseq_table #(.WIDTH(LIST_BITS), .RESET_WORD({11'h000, LIST_RESET})) u_list (    // [R7]
      .i_clock      (i_clock),
      .i_rst_b      (i_rst_b),
      .i_write      (list_write),
      .i_index      (o_table_index),
      .i_data       (i_port_wdata[LIST_BITS-1:0]),
      .i_scan_index (scan_entry),
      .o_host_word  (list_host),
      .o_scan_word  (list_scan)
   );

   always_comb begin
      next_table_index = o_table_index;
      next_port_rdata  = o_port_rdata;
      next_pin_analog  = i_analog_pin_select;                                   // [R12]
      if (i_port_read) begin
         if (i_list_access_select) begin                                        // [R4]
            next_port_rdata = {11'h000, list_host};
         end else if (i_high_threshold_select) begin
            next_port_rdata = {6'h00, high_host, 2'h0};
         end else begin
            next_port_rdata = {6'h00, low_host, 2'h0};
         end
      end
      if (i_index_load) begin
         next_table_index = i_index_value;
      end else if (i_port_read | i_port_write) begin
         next_table_index = o_table_index + 4'h1;                               // [R5]
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_table_index <= INDEX_RESET;
         o_port_rdata  <= 16'h0000;
         o_pin_analog  <= PIN_SELECT_RESET;                                     // [R12]
      end else begin
         o_table_index <= next_table_index;
         o_port_rdata  <= next_port_rdata;
         o_pin_analog  <= next_pin_analog;
      end
   end

   // -------------------------------------------------------------
   // scan engine
   // -------------------------------------------------------------
   // the comparator result is judged on the last cycle of each 1.6 us slot,
   // so the dac and mux have had at least 39 of its 40 cycles to settle
   tmseq_state_type state, next_state;
   logic [6:0]  wake_count, next_wake_count;
   logic [5:0]  slot_count, next_slot_count;
   logic [3:0]  next_scan_entry;
   logic [15:0] next_below, next_above;
   logic [15:0] below_set, above_set;
   logic        slot_done;

   assign slot_done = (slot_count == COMPARE_LAST);                            // [R11]

   always_comb begin
      next_state      = state;
      next_wake_count = wake_count;
      next_slot_count = slot_count;
      next_scan_entry = scan_entry;
      below_set       = 16'h0000;
      above_set       = 16'h0000;
      if (!i_monitor_enable) begin
         next_state      = TMSEQ_IDLE;
         next_wake_count = 7'h00;
         next_slot_count = 6'h00;
      end else begin
         unique case (state)
            TMSEQ_IDLE: begin
               next_state      = TMSEQ_WAKE;                                     // [R13]
               next_wake_count = 7'h00;
            end
            TMSEQ_WAKE: begin
               next_wake_count = wake_count + 7'h01;
               if (wake_count == WAKE_LAST) begin                                // [R13]
                  next_state      = TMSEQ_LOW;
                  next_scan_entry = i_scan_first_entry;                          // [R8]
                  next_slot_count = 6'h00;
               end
            end
            TMSEQ_LOW: begin
               next_slot_count = slot_count + 6'h01;
               if (slot_done) begin
                  next_slot_count = 6'h00;
                  next_state      = TMSEQ_HIGH;                                  // [R11]
                  if (!i_compare_above) begin
                     below_set[scan_entry] = 1'b1;                               // [R15] [R16] [R9]
                  end
               end
            end
            TMSEQ_HIGH: begin
               next_slot_count = slot_count + 6'h01;
               if (slot_done) begin
                  next_slot_count = 6'h00;
                  next_state      = TMSEQ_LOW;                                   // [R2]
                  if (i_compare_above) begin
                     above_set[scan_entry] = 1'b1;                               // [R15] [R16] [R9]
                  end
                  if (scan_entry == i_scan_last_entry) begin
                     next_scan_entry = i_scan_first_entry;                       // [R2] [R8]
                  end else begin
                     next_scan_entry = scan_entry + 4'h1;                        // [R14]
                  end
               end
            end
         endcase
      end
      // set beats a clear arriving in the same cycle
      next_below = (o_below_trip_flags & ~i_below_clear) | below_set;            // [R17]
      next_above = (o_above_trip_flags & ~i_above_clear) | above_set;            // [R17]
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state              <= TMSEQ_IDLE;
         wake_count         <= 7'h00;
         slot_count         <= 6'h00;
         scan_entry         <= INDEX_RESET;
         o_below_trip_flags <= FLAGS_RESET;
         o_above_trip_flags <= FLAGS_RESET;
      end else begin
         state              <= next_state;
         wake_count         <= next_wake_count;
         slot_count         <= next_slot_count;
         scan_entry         <= next_scan_entry;
         o_below_trip_flags <= next_below;
         o_above_trip_flags <= next_above;
      end
   end

   // -------------------------------------------------------------
   // analog front end drive
   // -------------------------------------------------------------
   logic [3:0] next_mux_channel;
   logic       next_pair_mode;
   logic [7:0] next_dac_code;
   logic       next_scanning;

   always_comb begin
      next_mux_channel = list_scan[CHANNEL_MSB:0];                               // [R1] [R7]
      next_pair_mode   = list_scan[PAIR_BIT];                                    // [R1]
      next_dac_code    = (next_state == TMSEQ_HIGH) ? high_scan : low_scan;      // [R10]
      next_scanning    = (state == TMSEQ_LOW) | (state == TMSEQ_HIGH);
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_mux_channel   <= 4'h0;
         o_mux_pair_mode <= 1'b0;
         o_dac_code      <= THRESH_RESET;
         o_scanning      <= 1'b0;
         o_scan_entry    <= INDEX_RESET;
      end else begin
         o_mux_channel   <= next_mux_channel;
         o_mux_pair_mode <= next_pair_mode;
         o_dac_code      <= next_dac_code;
         o_scanning      <= next_scanning;
         o_scan_entry    <= scan_entry;
      end
   end
endmodule
`default_nettype wire

//--- dv/tmseq_analog_model.sv
// analog inputs and fast comparator behind the channel mux
// assumes the sequencer drives mux and dac from registers on i_clock
`timescale 1ns/1ps
`default_nettype none
module tmseq_analog_model (
   input  wire logic         i_clock,
   input  wire logic [3:0]   i_channel,
   input  wire logic         i_pair_mode,
   input  wire logic [7:0]   i_dac_code,
   input  wire logic [15:0]  i_pin_analog,
   input  wire logic [127:0] i_levels,
   output logic              o_above
);
   logic       junk = 1'b0;
   logic [3:0] pin;
   always @(posedge i_clock) junk <= ~junk;
   // a digital pin gives the comparator nothing usable, so it sees noise
   always_comb begin
      pin     = i_pair_mode ? {i_channel[2:0], 1'b0} : i_channel;
      o_above = junk;
      if (i_pin_analog[pin]) begin
         o_above = i_levels[i_channel*8 +: 8] > i_dac_code;
      end
   end
endmodule
`default_nettype wire

//--- dv/tmseq_top_chk.sv
// port assertions for the threshold monitor sequencer
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
`default_nettype none
module tmseq_top_chk (
   input wire logic        i_clock,
   input wire logic        i_rst_b,
   input wire logic        i_monitor_enable,
   input wire logic        i_index_load,
   input wire logic [3:0]  i_index_value,
   input wire logic        i_port_write,
   input wire logic        i_port_read,
   input wire logic [3:0]  i_scan_first_entry,
   input wire logic [3:0]  i_scan_last_entry,
   input wire logic [3:0]  o_table_index,
   input wire logic [3:0]  o_scan_entry,
   input wire logic [15:0] i_analog_pin_select,
   input wire logic [15:0] i_below_clear,
   input wire logic [15:0] i_above_clear,
   input wire logic [15:0] o_pin_analog,
   input wire logic [15:0] o_below_trip_flags,
   input wire logic [15:0] o_above_trip_flags,
   input wire logic        o_scanning
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   a_index_step: assert property ((i_port_write || i_port_read) && !i_index_load
      |=> o_table_index == $past(o_table_index) + 4'h1) else $error("index step");
   a_index_load: assert property (i_index_load |=> o_table_index == $past(i_index_value))
      else $error("index load");
   a_pin_copy: assert property ($past(i_rst_b)
      |=> o_pin_analog == $past(i_analog_pin_select)) else $error("pin copy");
   a_wake_hold: assert property (i_monitor_enable && !$past(i_monitor_enable)
      |=> !o_scanning [*8]) else $error("scan before wake");
   // enable seen at edge 0, scanning shows high from edge 121, so it rises at edge 122
   a_wake_len: assert property ($rose(o_scanning) |-> $past(i_monitor_enable, 122))
      else $error("wake too short");
   a_idle_off: assert property (!i_monitor_enable ##1 !i_monitor_enable |=> !o_scanning)
      else $error("scan while off");
   a_entry_range: assert property (o_scanning |->
      ((i_scan_first_entry <= i_scan_last_entry) ?
      (o_scan_entry >= i_scan_first_entry && o_scan_entry <= i_scan_last_entry) :
      (o_scan_entry >= i_scan_first_entry || o_scan_entry <= i_scan_last_entry)))
      else $error("entry out of range");
   a_flag_single: assert property (
      $onehot0(o_below_trip_flags & ~$past(o_below_trip_flags)) &&
      $onehot0(o_above_trip_flags & ~$past(o_above_trip_flags)))
      else $error("flags set at once");
   a_flags_sticky: assert property (
      (($past(o_below_trip_flags) & ~$past(i_below_clear) & ~o_below_trip_flags) |
      ($past(o_above_trip_flags) & ~$past(i_above_clear) & ~o_above_trip_flags)) == 16'h0)
      else $error("flag lost");
endmodule
bind tmseq_top tmseq_top_chk tmseq_top_chk_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
   .i_monitor_enable(i_monitor_enable), .i_index_load(i_index_load), .i_index_value(i_index_value),
   .i_port_write(i_port_write), .i_port_read(i_port_read), .i_scan_first_entry(i_scan_first_entry),
   .i_scan_last_entry(i_scan_last_entry), .o_table_index(o_table_index), .o_scan_entry(o_scan_entry),
   .i_analog_pin_select(i_analog_pin_select), .i_below_clear(i_below_clear),
   .i_above_clear(i_above_clear), .o_pin_analog(o_pin_analog), .o_scanning(o_scanning),
   .o_below_trip_flags(o_below_trip_flags), .o_above_trip_flags(o_above_trip_flags));
`default_nettype wire

//--- dv/tmseq_top_tb.sv
// self-checking bench: port walks over the tables, then one wrapped scan
// assumes inputs change on the falling edge of a 40 ns clock
`timescale 1ns/1ps
`default_nettype none
module tmseq_top_tb;
   import tmseq_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, en = 1'b0, lsel = 1'b0, hsel = 1'b0, ld = 1'b0, wr = 1'b0;
   logic rd = 1'b0, above;
   logic [3:0] ival = 4'h0, first = 4'h6, last = 4'h1, tidx, mch, sent;
   logic [15:0] wdat = 16'h0, pins = 16'h0, bclr = 16'h0, aclr = 16'h0, rdat, pan, bfl, afl;
   logic [15:0] eb = 16'h0, ea = 16'h0;
   logic [7:0] dac, lo [16], hi [16], lvl [16];
   logic [4:0] lst [16];
   logic [127:0] levels;
   logic pair, scan;
   int num_errors = 0, checks_done = 0;
   initial forever #20 clk = ~clk;
   tmseq_top tmseq_top_i (.i_clock(clk), .i_rst_b(rst_b), .i_monitor_enable(en),
      .i_list_access_select(lsel), .i_high_threshold_select(hsel), .i_index_load(ld),
      .i_index_value(ival), .i_port_write(wr), .i_port_read(rd), .i_port_wdata(wdat),
      .i_scan_first_entry(first), .i_scan_last_entry(last), .i_analog_pin_select(pins),
      .i_compare_above(above), .i_below_clear(bclr), .i_above_clear(aclr), .o_table_index(tidx),
      .o_port_rdata(rdat), .o_pin_analog(pan), .o_mux_channel(mch), .o_mux_pair_mode(pair),
      .o_dac_code(dac), .o_scanning(scan), .o_scan_entry(sent), .o_below_trip_flags(bfl),
      .o_above_trip_flags(afl));
   tmseq_analog_model tmseq_analog_model_i (.i_clock(clk), .i_channel(mch), .i_pair_mode(pair),
      .i_dac_code(dac), .i_pin_analog(pan), .i_levels(levels), .o_above(above));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one port access at the falling edge; the strobe is left up so that
   // back-to-back calls never lower and raise it in one time step
   task automatic port(input logic w, input logic [15:0] d);
      wr <= w;
      rd <= !w;
      wdat <= d;
      @(negedge clk);
   endtask
   function automatic logic [15:0] word(input int t, input int k);
      return (t == 2) ? {11'h0, lst[k]} : {6'h0, (t == 1) ? hi[k] : lo[k], 2'b00};
   endfunction
   initial begin
      int n, t, prev, nxt, cnt;
      for (int k = 0; k < 16; k++) begin
         lo[k] = 8'(k * 23);
         hi[k] = 8'(k * 23 + 100);
         lst[k] = {k[3], 1'b0, 3'(k * 3)};
         lvl[k] = 8'(k * 37);
         levels[k*8 +: 8] = lvl[k];
      end
      repeat (6) @(negedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("reset flags", 16'h0, bfl | afl);
      chk("reset pins", 16'h0, pan);
      for (t = 0; t < 3; t++) begin
         wr <= 1'b0;
         rd <= 1'b0;
         lsel <= (t == 2);
         hsel <= (t == 1);
         ival <= 4'h0;
         ld <= 1'b1;
         @(negedge clk);
         ld <= 1'b0;
         for (int k = 0; k < 16; k++) begin
            port(1'b1, word(t, k) | ((t == 2) ? 16'hffe0 : 16'h0));
         end
         chk("index wrap", 16'h0, {12'h0, tidx});
         for (int k = 0; k < 16; k++) begin
            port(1'b0, 16'h0);
            chk("table read", word(t, k), rdat & ((t == 2) ? 16'hffff : 16'h03fc));
         end
      end
      rd <= 1'b0;
      pins <= 16'hffff;
      en <= 1'b1;
      n = 0;
      cnt = 0;
      prev = -1;
      while (cnt < 13 && n < 2000) begin
         @(negedge clk);
         n++;
         t++;
         if (scan && int'(sent) != prev) begin
            if (prev < 0) chk("wake", 16'h1, 16'(n >= 120 && n <= 123));
            else chk("entry time", 16'(2 * COMPARE_CYCLES), 16'(t));
            nxt = (prev == int'(last) || prev < 0) ? int'(first) : (prev + 1) % 16;
            chk("entry order", 16'(nxt), {12'h0, sent});
            prev = int'(sent);
            cnt++;
            t = 0;
         end
         // mid-slot looks: low threshold in the first slot, high in the second
         if (prev >= 0 && t == 20) chk("dac low", {8'h0, lo[prev]}, {8'h0, dac});
         if (prev >= 0 && t == 40) begin
            chk("mux", {11'h0, lst[prev]}, {11'h0, pair, mch});
         end
         if (prev >= 0 && t == 60) chk("dac high", {8'h0, hi[prev]}, {8'h0, dac});
      end
      chk("scan entries", 16'h000d, 16'(cnt));
      en <= 1'b0;
      for (int k = 0; k < 16; k++) if (k >= 6 || k <= 1) begin
         eb[k] = lvl[lst[k][3:0]] <= lo[k];
         ea[k] = lvl[lst[k][3:0]] > hi[k];
      end
      repeat (3) @(negedge clk);
      chk("below flags", eb, bfl);
      chk("above flags", ea, afl);
      bclr <= 16'hffff;
      @(negedge clk);
      bclr <= 16'h0;
      repeat (2) @(negedge clk);
      chk("below cleared", 16'h0, bfl);
      chk("above kept", ea, afl);
      aclr <= 16'hffff;
      @(negedge clk);
      aclr <= 16'h0;
      @(negedge clk);
      chk("above cleared", 16'h0, afl);
      final_report();
   end
   initial begin
      #200000;
      num_errors++;
      final_report();
   end
endmodule
`default_nettype wire
